/* verilog/write_family_command_exec.sv */
// write, mark-invalid and write-zeroes command executor with AXI4-Lite control registers
// Functional notes
// (RULE1) write reference tag from dword 14
// (RULE2) write app mask/tag from dword 15
// (RULE3) one completion per command, success or failure
// (RULE4) conflicting write attributes give status 80h
// (RULE5) bad protection settings give status 81h
// (RULE6) marked blocks fail reads with unrecovered error
// (RULE7) a write clears the invalid mark
// (RULE8) mark-invalid uses only dwords 10 to 12
// (RULE9) start address: dword 10 low, 11 high
// (RULE10) mark-invalid count is dword 12 low half
// (RULE11) write-zeroes count is dword 12 low half
// (RULE12) zeroed blocks read zero until rewritten
// (RULE13) bit 31 asks for limited retry
// (RULE14) bit 30 commits to media before completion
// (RULE15) bits 29:26 select protection action
// (RULE16) write-zeroes reference tag from dword 14
// (RULE17) write-zeroes app tag from dword 15 low
// (RULE18) write-zeroes decodes dwords 10,11,12,14,15 only
//
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "wfc_defs.svh"
module write_family_command_exec #(
  parameter int NUM_BLOCKS = 64,
  parameter logic [7:0] OPC_WRITE = 8'h01,
  parameter logic [7:0] OPC_MARK_INVALID = 8'h04,
  parameter logic [7:0] OPC_ZEROES = 8'h08
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // command in
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic [7:0] cmdOpcode,
  input wire logic [15:0] cmdId,
  input wire logic [15:0] cmdSqId,
  input wire logic [31:0] cdw10,
  input wire logic [31:0] cdw11,
  input wire logic [31:0] cdw12,
  input wire logic [31:0] cdw13,
  input wire logic [31:0] cdw14,
  input wire logic [31:0] cdw15,
  input wire logic nsProtected,
  // completion out
  output logic cplValid,
  input wire logic cplReady,
  output logic [15:0] cplId,
  output logic [15:0] cplSqId,
  output logic [2:0] cplStatusType,
  output logic [7:0] cplStatusCode,
  // media side
  output logic limited_retry_flag,
  output logic force_media_commit,
  output logic [3:0] protection_action_sel,
  output logic [31:0] initial_reference_tag,
  output logic [15:0] app_tag_mask,
  output logic [15:0] app_tag,
  output logic commitReq,
  input wire logic commitDone,
  // block read query
  input wire logic rdReq,
  input wire logic [63:0] rdAddr,
  output logic rdValid,
  output logic rdError,
  output logic rdZero,
  // axi4-lite slave
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // interrupt
  output logic irq
);
  localparam int IDXW = $clog2(NUM_BLOCKS);

  // the block maps are indexed by address bits, so only powers of two fit
  if (NUM_BLOCKS < 2 || NUM_BLOCKS > 65536 || (1 << IDXW) != NUM_BLOCKS)
  begin : gBadBlocks
    $error("NUM_BLOCKS must be a power of two from 2 to 65536");
  end

  typedef struct packed {
    wfc_pkg::state_t st;
    wfc_pkg::kind_t kind;
    logic [15:0] cid;
    logic [15:0] sqid;
    logic [63:0] startAddr;
    logic [IDXW-1:0] cursor;
    logic [16:0] remain;
    logic commitFlag;
    logic retryFlag;
    logic [3:0] protSel;
    logic [31:0] refTag;
    logic [15:0] appMask;
    logic [15:0] appTag;
    logic [2:0] sType;
    logic [7:0] sCode;
    logic [NUM_BLOCKS-1:0] invalidMap;
    logic [NUM_BLOCKS-1:0] zeroMap;
    logic commitSeen;
    logic cplValid;
    logic rdValid;
    logic rdErr;
    logic rdZero;
    logic ctrlEn;
    logic [1:0] intSts;
    logic [1:0] intMask;
    logic [31:0] cplCount;
    logic awHeld;
    logic [5:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
  } state_q_t;

  state_q_t s_q;
  state_q_t s_d;

  // inclusive range must end inside the block store
  function automatic logic rangeOk(input logic [63:0] addr, input logic [15:0] cnt);
    logic [64:0] last;
    last = {1'b0, addr} + {49'h0, cnt};
    return last < 65'(NUM_BLOCKS);
  endfunction : rangeOk

  // checks requested without end-to-end protection formatting are invalid
  function automatic logic piBad(input logic [3:0] sel, input logic prot);
    return !prot && (sel[2:0] != 3'h0);
  endfunction : piBad

  function automatic logic [1:0] regResp(input logic [5:0] a);
    logic known;
    known = (a == `WFC_REG_CTRL) || (a == `WFC_REG_INT_STS) || (a == `WFC_REG_INT_MASK)
      || (a == `WFC_REG_CPL_COUNT) || (a == `WFC_REG_LAST_STS);
    return known ? 2'h0 : 2'h3;
  endfunction : regResp

  logic cmdTake;
  logic cplTake;
  logic [7:0] cmdSc;
  logic [2:0] cmdSct;
  wfc_pkg::kind_t cmdKind;
  logic [1:0] intEvt;
  logic awTake;
  logic wTake;
  logic arTake;

  assign cmdReady = (s_q.st == wfc_pkg::ST_IDLE) && s_q.ctrlEn;
  assign cmdTake = cmdValid && cmdReady;
  assign cplTake = s_q.cplValid && cplReady;
  assign awTake = s_axi_awvalid && !s_q.awHeld && !s_q.bValid;
  assign wTake = s_axi_wvalid && !s_q.wHeld && !s_q.bValid;
  assign arTake = s_axi_arvalid && !s_q.rValid;

  always_comb
  begin
    cmdKind = wfc_pkg::KIND_OTHER;
    cmdSct = `WFC_SCT_GENERIC;
    cmdSc = `WFC_SC_SUCCESS;
    if (cmdOpcode == OPC_WRITE)
    begin
      cmdKind = wfc_pkg::KIND_WRITE;
    end
    else if (cmdOpcode == OPC_MARK_INVALID)
    begin
      cmdKind = wfc_pkg::KIND_MARK_INVALID;
    end
    else if (cmdOpcode == OPC_ZEROES)
    begin
      cmdKind = wfc_pkg::KIND_ZEROES;
    end
    if (cmdKind == wfc_pkg::KIND_OTHER)
    begin
      cmdSc = `WFC_SC_BAD_OPCODE;
    end
    else if (cmdKind != wfc_pkg::KIND_MARK_INVALID
      && piBad(cdw12[`WFC_PROT_MSB:`WFC_PROT_LSB], nsProtected))
    begin
      cmdSct = `WFC_SCT_CMDSPEC;
      cmdSc = `WFC_SC_BAD_PI; // RULE5
    end
    else if (cmdKind == wfc_pkg::KIND_WRITE && cdw13[`WFC_FREQ_MSB:0] >= `WFC_FREQ_RSVD_MIN)
    begin
      cmdSct = `WFC_SCT_CMDSPEC;
      cmdSc = `WFC_SC_CONFLICT; // RULE4
    end
    else if (!rangeOk({cdw11, cdw10}, cdw12[`WFC_COUNT_MSB:0]))
    begin
      cmdSc = `WFC_SC_LBA_RANGE;
    end
  end

  assign intEvt[`WFC_INT_DONE] = cplTake;
  assign intEvt[`WFC_INT_ERR] = cplTake && (s_q.sCode != `WFC_SC_SUCCESS);

  always_comb
  begin
    s_d = s_q;
    s_d.rdValid = 1'b0;
    case (s_q.st)
      wfc_pkg::ST_IDLE:
      begin
        if (cmdTake)
        begin
          s_d.kind = cmdKind;
          s_d.cid = cmdId;
          s_d.sqid = cmdSqId;
          s_d.startAddr = {cdw11, cdw10}; // RULE9
          s_d.cursor = cdw10[IDXW-1:0];
          s_d.remain = {1'b0, cdw12[`WFC_COUNT_MSB:0]} + 17'h1; // RULE10 RULE11
          s_d.commitSeen = 1'b0;
          s_d.sType = cmdSct;
          s_d.sCode = cmdSc;
          // mark-invalid ignores dwords 13 to 15 and the upper dword 12 bits
          s_d.commitFlag = 1'b0; // RULE8
          s_d.retryFlag = 1'b0;
          s_d.protSel = 4'h0;
          if (cmdKind != wfc_pkg::KIND_MARK_INVALID)
          begin
            s_d.commitFlag = cdw12[`WFC_COMMIT_BIT]; // RULE14
            s_d.retryFlag = cdw12[`WFC_RETRY_BIT]; // RULE13
            s_d.protSel = cdw12[`WFC_PROT_MSB:`WFC_PROT_LSB]; // RULE15
            // tags only meaningful on protected namespaces
            if (nsProtected)
            begin
              s_d.refTag = cdw14[`WFC_REFTAG_MSB:0]; // RULE1 RULE16 RULE18
              s_d.appMask = cdw15[`WFC_APPMASK_MSB:`WFC_APPMASK_LSB]; // RULE2
              s_d.appTag = cdw15[`WFC_APPTAG_MSB:0]; // RULE2 RULE17
            end
          end
          s_d.st = (cmdSc == `WFC_SC_SUCCESS) ? wfc_pkg::ST_WALK : wfc_pkg::ST_POST;
          s_d.cplValid = (cmdSc != `WFC_SC_SUCCESS); // RULE3
        end
      end
      wfc_pkg::ST_WALK:
      begin
        // one block per cycle keeps the maps single-ported
        case (s_q.kind)
          wfc_pkg::KIND_MARK_INVALID:
          begin
            s_d.invalidMap[s_q.cursor] = 1'b1; // RULE6
            s_d.zeroMap[s_q.cursor] = 1'b0;
          end
          wfc_pkg::KIND_ZEROES:
          begin
            s_d.zeroMap[s_q.cursor] = 1'b1; // RULE12
            s_d.invalidMap[s_q.cursor] = 1'b0;
          end
          default:
          begin
            s_d.invalidMap[s_q.cursor] = 1'b0; // RULE7
            s_d.zeroMap[s_q.cursor] = 1'b0; // RULE12
          end
        endcase
        s_d.cursor = s_q.cursor + IDXW'(1);
        s_d.remain = s_q.remain - 17'h1;
        if (s_q.remain == 17'h1)
        begin
          s_d.st = s_q.commitFlag ? wfc_pkg::ST_COMMIT : wfc_pkg::ST_POST; // RULE14
          s_d.cplValid = !s_q.commitFlag;
        end
      end
      wfc_pkg::ST_COMMIT:
      begin
        if (commitDone)
        begin
          s_d.commitSeen = 1'b1; // RULE14
          s_d.st = wfc_pkg::ST_POST;
          s_d.cplValid = 1'b1;
        end
      end
      wfc_pkg::ST_POST:
      begin
        if (cplReady)
        begin
          s_d.cplValid = 1'b0;
          s_d.cplCount = s_q.cplCount + 32'h1;
          s_d.st = wfc_pkg::ST_IDLE;
        end
      end
      default:
      begin
        s_d.st = wfc_pkg::ST_IDLE;
      end
    endcase

    // block reads answer one cycle after the query
    if (rdReq)
    begin
      s_d.rdValid = 1'b1;
      s_d.rdErr = (rdAddr < 64'(NUM_BLOCKS)) && s_q.invalidMap[rdAddr[IDXW-1:0]]; // RULE6
      s_d.rdZero = (rdAddr < 64'(NUM_BLOCKS)) && s_q.zeroMap[rdAddr[IDXW-1:0]]; // RULE12
    end

    // axi write channel; address and data may arrive in either order
    if (awTake)
    begin
      s_d.awHeld = 1'b1;
      s_d.awAddr = s_axi_awaddr;
    end
    if (wTake)
    begin
      s_d.wHeld = 1'b1;
      s_d.wData = s_axi_wdata;
      s_d.wStrb = s_axi_wstrb;
    end
    s_d.intSts = s_q.intSts;
    if (s_q.awHeld && s_q.wHeld && !s_q.bValid)
    begin
      s_d.awHeld = 1'b0;
      s_d.wHeld = 1'b0;
      s_d.bValid = 1'b1;
      s_d.bResp = regResp(s_q.awAddr);
      if (s_q.wStrb[0])
      begin
        case (s_q.awAddr)
          `WFC_REG_CTRL: s_d.ctrlEn = s_q.wData[0];
          `WFC_REG_INT_STS: s_d.intSts = s_q.intSts & ~s_q.wData[1:0];
          `WFC_REG_INT_MASK: s_d.intMask = s_q.wData[1:0];
          default: s_d.bResp = regResp(s_q.awAddr);
        endcase
      end
    end
    // a new event wins over a clear in the same cycle
    s_d.intSts = s_d.intSts | intEvt;
    if (s_q.bValid && s_axi_bready)
    begin
      s_d.bValid = 1'b0;
    end

    // axi read channel
    if (arTake)
    begin
      s_d.rValid = 1'b1;
      s_d.rResp = regResp(s_axi_araddr);
      case (s_axi_araddr)
        `WFC_REG_CTRL: s_d.rData = {31'h0, s_q.ctrlEn};
        `WFC_REG_INT_STS: s_d.rData = {30'h0, s_q.intSts};
        `WFC_REG_INT_MASK: s_d.rData = {30'h0, s_q.intMask};
        `WFC_REG_CPL_COUNT: s_d.rData = s_q.cplCount;
        `WFC_REG_LAST_STS: s_d.rData = {11'h0, s_q.st != wfc_pkg::ST_IDLE, s_q.cid[7:0], s_q.sType, 1'b0, s_q.sCode};
        default: s_d.rData = 32'h0;
      endcase
    end
    else if (s_q.rValid && s_axi_rready)
    begin
      s_d.rValid = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
      s_q.ctrlEn <= `WFC_CTRL_RESET;
      s_q.intMask <= `WFC_MASK_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign cplValid = s_q.cplValid;
  assign cplId = s_q.cid;
  assign cplSqId = s_q.sqid;
  assign cplStatusType = s_q.sType;
  assign cplStatusCode = s_q.sCode;
  assign limited_retry_flag = s_q.retryFlag;
  assign force_media_commit = s_q.commitFlag;
  assign protection_action_sel = s_q.protSel;
  assign initial_reference_tag = s_q.refTag;
  assign app_tag_mask = s_q.appMask;
  assign app_tag = s_q.appTag;
  assign commitReq = (s_q.st == wfc_pkg::ST_COMMIT);
  assign rdValid = s_q.rdValid;
  assign rdError = s_q.rdErr;
  assign rdZero = s_q.rdZero;
  assign s_axi_awready = !s_q.awHeld && !s_q.bValid;
  assign s_axi_wready = !s_q.wHeld && !s_q.bValid;
  assign s_axi_bvalid = s_q.bValid;
  assign s_axi_bresp = s_q.bResp;
  assign s_axi_arready = !s_q.rValid;
  assign s_axi_rvalid = s_q.rValid;
  assign s_axi_rdata = s_q.rData;
  assign s_axi_rresp = s_q.rResp;
  assign irq = |(s_q.intSts & s_q.intMask);

  refTagCapture_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
    cmdTake && nsProtected && cmdKind == wfc_pkg::KIND_WRITE |=> initial_reference_tag == $past(cdw14))
    else $error("reference tag not captured");

  appTagCapture_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
    cmdTake && nsProtected && cmdKind != wfc_pkg::KIND_MARK_INVALID
    |=> app_tag_mask == $past(cdw15[31:16]) && app_tag == $past(cdw15[15:0]))
    else $error("application tag fields not captured");

  oneCompletion_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
    cmdTake && !cdw12[30] |-> ##[1:70] cplValid)
    else $error("command not completed in time");

  conflictCode_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
    cmdTake && cmdKind == wfc_pkg::KIND_WRITE && !piBad(cdw12[29:26], nsProtected) && cdw13[3:0] >= 4'h7
    |=> cplValid && cplStatusCode == 8'h81 - 8'h1 && cplStatusType == 3'h1)
    else $error("conflicting attributes not reported");

  badPiCode_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE5
    cmdTake && cmdKind != wfc_pkg::KIND_MARK_INVALID && cmdKind != wfc_pkg::KIND_OTHER
    && piBad(cdw12[29:26], nsProtected) |=> cplValid && cplStatusCode == 8'h81)
    else $error("invalid protection settings not reported");

  invalidRead_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
    rdReq && rdAddr < 64'(NUM_BLOCKS) && s_q.invalidMap[rdAddr[IDXW-1:0]] |=> rdValid && rdError)
    else $error("read of invalid block did not fail");

  startAddr_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
    cmdTake |=> s_q.startAddr == {$past(cdw11), $past(cdw10)})
    else $error("start address mis-assembled");

  zeroRead_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE12
    rdReq && rdAddr < 64'(NUM_BLOCKS) && s_q.zeroMap[rdAddr[IDXW-1:0]] |=> rdValid && rdZero)
    else $error("zeroed block did not read zero");

  mediaCommit_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE14
    $rose(cplValid) && force_media_commit && cplStatusCode == 8'h00 |-> s_q.commitSeen)
    else $error("completion before media commit");
endmodule : write_family_command_exec

/* verilog/wfc_defs.svh */
// offsets, field positions, reset values and status codes of the write-family executor
`ifndef WFC_DEFS_SVH
`define WFC_DEFS_SVH
`define WFC_REG_CTRL 6'h00
`define WFC_REG_INT_STS 6'h04
`define WFC_REG_INT_MASK 6'h08
`define WFC_REG_CPL_COUNT 6'h0C
`define WFC_REG_LAST_STS 6'h10
`define WFC_CTRL_RESET 1'h1
`define WFC_MASK_RESET 2'h0
`define WFC_INT_DONE 0
`define WFC_INT_ERR 1
`define WFC_REFTAG_MSB 31
`define WFC_APPMASK_MSB 31
`define WFC_APPMASK_LSB 16
`define WFC_APPTAG_MSB 15
`define WFC_COUNT_MSB 15
`define WFC_RETRY_BIT 31
`define WFC_COMMIT_BIT 30
`define WFC_PROT_MSB 29
`define WFC_PROT_LSB 26
`define WFC_FREQ_MSB 3
`define WFC_FREQ_RSVD_MIN 4'h7
`define WFC_SCT_GENERIC 3'h0
`define WFC_SCT_CMDSPEC 3'h1
`define WFC_SCT_MEDIA 3'h2
`define WFC_SC_SUCCESS 8'h00
`define WFC_SC_BAD_OPCODE 8'h01
`define WFC_SC_LBA_RANGE 8'h80
`define WFC_SC_CONFLICT 8'h80
`define WFC_SC_BAD_PI 8'h81
`define WFC_SC_UNRECOVERED 8'h81
`endif

/* verilog/wfc_pkg.sv */
// types shared by the write-family executor
package wfc_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WALK = 2'b01,
    ST_COMMIT = 2'b10,
    ST_POST = 2'b11
  } state_t;
  typedef enum logic [1:0] {
    KIND_WRITE = 2'b00,
    KIND_MARK_INVALID = 2'b01,
    KIND_ZEROES = 2'b10,
    KIND_OTHER = 2'b11
  } kind_t;
endpackage : wfc_pkg

/* sim/host_model.sv */
// host-side model: accepts completions and answers media commits
`timescale 1ns/100ps
module host_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // completion queue side
  input wire logic cplValid,
  output logic cplReady,
  // media commit side
  input wire logic commitReq,
  output logic commitDone,
  output logic [7:0] commitCount
);
  logic [1:0] waitQ;
  // ready one cycle late, so a completion must hold its fields
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cplReady <= 1'b0;
      commitDone <= 1'b0;
      waitQ <= 2'h0;
      commitCount <= 8'h00;
    end
    else
    begin
      cplReady <= cplValid && !cplReady;
      // slow media: four cycles before the commit is confirmed
      commitDone <= commitReq && !commitDone && waitQ == 2'h3;
      if (commitDone)
        waitQ <= 2'h0;
      else if (commitReq)
        waitQ <= waitQ + 2'h1;
      if (commitDone)
        commitCount <= commitCount + 8'h01;
    end
  end
endmodule : host_model

/* sim/testbench.sv */
// self-checking bench for the write-family executor
`timescale 1ns/100ps
`include "wfc_defs.svh"
module testbench;
  localparam logic [7:0] WR = 8'h01;
  localparam logic [7:0] MK = 8'h04;
  localparam logic [7:0] ZR = 8'h08;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmdValid = 1'b0;
  logic [7:0] cmdOpcode = 8'h00;
  logic [15:0] cmdId = 16'h0000;
  logic [15:0] cmdSqId = 16'h0003;
  logic [31:0] cdw10 = 32'h0, cdw11 = 32'h0, cdw12 = 32'h0, cdw13 = 32'h0, cdw14 = 32'h0, cdw15 = 32'h0;
  logic nsProtected = 1'b0;
  logic rdReq = 1'b0;
  logic [63:0] rdAddr = 64'h0;
  logic [5:0] awaddr = 6'h00, araddr = 6'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic cmdReady, cplValid, cplReady, commitReq, commitDone, rdValid, rdError, rdZero, irq;
  logic limited_retry_flag, force_media_commit;
  logic [3:0] protection_action_sel;
  logic [31:0] initial_reference_tag, rdata;
  logic [15:0] app_tag_mask, app_tag, cplId, cplSqId;
  logic [2:0] cplStatusType;
  logic [7:0] cplStatusCode, commitCount;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int badCount = 0;
  int compares = 0;
  int nCpl = 0;
  write_family_command_exec #(.NUM_BLOCKS(64), .OPC_WRITE(WR), .OPC_MARK_INVALID(MK), .OPC_ZEROES(ZR))
    write_family_command_exec_i (.clk(clk), .rst_n(rst_n), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .cmdOpcode(cmdOpcode), .cmdId(cmdId), .cmdSqId(cmdSqId), .cdw10(cdw10), .cdw11(cdw11), .cdw12(cdw12),
    .cdw13(cdw13), .cdw14(cdw14), .cdw15(cdw15), .nsProtected(nsProtected), .cplValid(cplValid),
    .cplReady(cplReady), .cplId(cplId), .cplSqId(cplSqId), .cplStatusType(cplStatusType),
    .cplStatusCode(cplStatusCode), .limited_retry_flag(limited_retry_flag),
    .force_media_commit(force_media_commit), .protection_action_sel(protection_action_sel),
    .initial_reference_tag(initial_reference_tag), .app_tag_mask(app_tag_mask), .app_tag(app_tag),
    .commitReq(commitReq), .commitDone(commitDone), .rdReq(rdReq), .rdAddr(rdAddr), .rdValid(rdValid),
    .rdError(rdError), .rdZero(rdZero), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));
  host_model host_model_i (.clk(clk), .rst_n(rst_n), .cplValid(cplValid), .cplReady(cplReady),
    .commitReq(commitReq), .commitDone(commitDone), .commitCount(commitCount));
  initial
  begin
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    compares++;
    if (s !== e)
    begin
      $display("unexpected at %0t: seen %0h expected %0h", $time, s, e);
      badCount++;
    end
  endtask : chk
  task end_of_test;
    if (badCount == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  // handshakes are judged on values settled before the edge, never in its time step
  task automatic axw(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic awHs, wHs, bHs;
    logic [1:0] resp;
    n = 0;
    bHs = 1'b0;
    resp = 2'h0;
    @(posedge clk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    do
    begin
      @(negedge clk);
      awHs = awvalid && awready === 1'b1;
      wHs = wvalid && wready === 1'b1;
      bHs = bvalid === 1'b1;
      resp = bresp;
      @(posedge clk);
      n++;
      if (awHs)
        awvalid <= 1'b0;
      if (wHs)
        wvalid <= 1'b0;
    end
    while (!bHs && n < 50);
    bready <= 1'b0;
    chk({n < 50, resp}, {1'b1, er});
  endtask : axw
  task automatic axr(input logic [5:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    logic arHs, rHs;
    logic [1:0] resp;
    logic [31:0] data;
    n = 0;
    rHs = 1'b0;
    resp = 2'h0;
    data = 32'h0;
    @(posedge clk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do
    begin
      @(negedge clk);
      arHs = arvalid && arready === 1'b1;
      rHs = rvalid === 1'b1;
      resp = rresp;
      data = rdata;
      @(posedge clk);
      n++;
      if (arHs)
        arvalid <= 1'b0;
    end
    while (!rHs && n < 50);
    rready <= 1'b0;
    chk({n < 50, resp, data}, {1'b1, er, ed});
  endtask : axr
  // one command, then its completion judged at the handshake edge
  task automatic cmd(input logic [7:0] op, input logic [31:0] d10, d11, d12, d13, d14, d15,
    input logic pr, input logic [2:0] et, input logic [7:0] ec);
    int n;
    logic hs;
    logic [42:0] seen;
    n = 0;
    hs = 1'b0;
    seen = 43'h0;
    @(posedge clk);
    {cmdValid, cmdOpcode, cdw10, cdw11, cdw12, cdw13, cdw14, cdw15, nsProtected} <=
      {1'b1, op, d10, d11, d12, d13, d14, d15, pr};
    cmdId <= cmdId + 16'h0001;
    do
    begin
      @(negedge clk);
      hs = cmdReady === 1'b1;
      @(posedge clk);
      n++;
    end
    while (!hs && n < 100);
    cmdValid <= 1'b0;
    do
    begin
      @(negedge clk);
      hs = cplValid === 1'b1 && cplReady === 1'b1;
      seen = {cplStatusType, cplStatusCode, cplId, cplSqId};
      @(posedge clk);
      n++;
    end
    while (!hs && n < 300);
    nCpl++;
    chk({n < 300, seen}, {1'b1, et, ec, cmdId, 16'h0003});
  endtask : cmd
  task automatic rd(input logic [63:0] a, input logic er, input logic ez);
    @(posedge clk);
    {rdReq, rdAddr} <= {1'b1, a};
    @(posedge clk);
    rdReq <= 1'b0;
    #1;
    chk({rdValid, rdError, rdZero}, {1'b1, er, ez});
  endtask : rd
  task t_regs;
    axr(`WFC_REG_CTRL, 32'h00000001, 2'h0);
    axr(`WFC_REG_INT_MASK, 32'h00000000, 2'h0);
    axw(`WFC_REG_CTRL, 32'h00000000, 2'h0);
    chk(cmdReady, 1'b0);
    axr(`WFC_REG_CTRL, 32'h00000000, 2'h0);
    axw(`WFC_REG_CTRL, 32'h00000001, 2'h0);
    chk(cmdReady, 1'b1);
    axw(6'h3C, 32'h0000000F, 2'h3);
    axr(6'h3C, 32'h00000000, 2'h3);
  endtask : t_regs
  task t_mark;
    cmd(MK, 32'h5, 32'h0, 32'h00000001, 32'h0, 32'h0, 32'h0, 1'b0, 3'h0, 8'h00);
    rd(64'h4, 1'b0, 1'b0);
    rd(64'h5, 1'b1, 1'b0);
    rd(64'h6, 1'b1, 1'b0);
    rd(64'h7, 1'b0, 1'b0);
    // reserved upper half must not widen the range
    cmd(MK, 32'h14, 32'h0, 32'hFFFF0000, 32'h0, 32'h0, 32'h0, 1'b0, 3'h0, 8'h00);
    rd(64'h15, 1'b0, 1'b0);
    cmd(MK, 32'h5, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 1'b0, 3'h0, 8'h80);
    cmd(MK, 32'h3F, 32'h0, 32'h00000001, 32'h0, 32'h0, 32'h0, 1'b0, 3'h0, 8'h80);
  endtask : t_mark
  task t_zero;
    cmd(MK, 32'hA, 32'h0, 32'h00000001, 32'h0, 32'h0, 32'h0, 1'b0, 3'h0, 8'h00);
    cmd(ZR, 32'hA, 32'h0, 32'hD7FF0001, 32'h0, 32'hA5A55A5A, 32'h9876BEEF, 1'b1, 3'h0, 8'h00);
    chk({limited_retry_flag, force_media_commit, protection_action_sel}, {2'b11, 4'h5});
    chk({initial_reference_tag, app_tag}, {32'hA5A55A5A, 16'hBEEF});
    chk(commitCount, 8'h01);
    rd(64'hA, 1'b0, 1'b1);
    rd(64'hB, 1'b0, 1'b1);
    rd(64'hC, 1'b0, 1'b0);
    cmd(ZR, 32'h20, 32'h0, 32'h04000000, 32'h0, 32'h0, 32'h0, 1'b0, 3'h1, 8'h81);
    rd(64'h20, 1'b0, 1'b0);
  endtask : t_zero
  task t_write;
    cmd(WR, 32'h5, 32'h0, 32'h0, 32'h0, 32'hDEAD0001, 32'hF0F01234, 1'b1, 3'h0, 8'h00);
    chk({initial_reference_tag, app_tag_mask, app_tag}, {32'hDEAD0001, 16'hF0F0, 16'h1234});
    rd(64'h5, 1'b0, 1'b0);
    rd(64'h6, 1'b1, 1'b0);
    cmd(WR, 32'hA, 32'h0, 32'h0, 32'h6, 32'h11111111, 32'h22222222, 1'b0, 3'h0, 8'h00);
    chk({initial_reference_tag, app_tag_mask, app_tag}, {32'hDEAD0001, 16'hF0F0, 16'h1234});
    rd(64'hA, 1'b0, 1'b0);
    cmd(WR, 32'h6, 32'h0, 32'h0, 32'h7, 32'h0, 32'h0, 1'b1, 3'h1, 8'h80);
    cmd(WR, 32'h6, 32'h0, 32'h04000000, 32'h0, 32'h0, 32'h0, 1'b0, 3'h1, 8'h81);
    rd(64'h6, 1'b1, 1'b0);
    cmd(8'h02, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 1'b0, 3'h0, 8'h01);
  endtask : t_write
  task t_irq;
    axr(`WFC_REG_INT_STS, 32'h00000003, 2'h0);
    chk(irq, 1'b0);
    axw(`WFC_REG_INT_MASK, 32'h00000003, 2'h0);
    chk(irq, 1'b1);
    axw(`WFC_REG_INT_STS, 32'h00000001, 2'h0);
    axr(`WFC_REG_INT_STS, 32'h00000002, 2'h0);
    axw(`WFC_REG_INT_MASK, 32'h00000001, 2'h0);
    chk(irq, 1'b0);
    axr(`WFC_REG_CPL_COUNT, nCpl, 2'h0);
    axr(`WFC_REG_LAST_STS, {12'h000, cmdId[7:0], 12'h001}, 2'h0);
  endtask : t_irq
  initial
  begin
    #400000;
    badCount++;
    end_of_test();
  end
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_mark();
    t_zero();
    t_write();
    t_irq();
    end_of_test();
  end
endmodule : testbench
